// ### dflp_fault_latch.sv
`timescale 1ns/1ps

module dflp_fault_latch
    import dflp_pkg::*;
#(
    parameter int unsigned SHORT_OFF_CYCLES = SHORT_OFF_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    // Drive parameter access
    input  wire logic        mask_wr_in,
    input  wire logic [31:0] mask_wdata_in,
    output logic      [31:0] mask_rdata_out,
    input  wire logic        fault_clr_in,
    input  wire logic [31:0] fault_clr_data_in,
    output logic      [31:0] latched_faults_out,
    output logic      [31:0] event_status_out,
    // Fault sources from drive sensing
    input  wire dflp_src_t   fault_src_in,
    // Drive control
    input  wire logic        enable_req_in,
    output logic             drive_enable_out,
    output logic             abort_move_out
);

    localparam int unsigned CNT_W = $clog2(SHORT_OFF_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SHORT_OFF_CYCLES - 1);

    // ************************************************************
    // State
    // ************************************************************
    logic [31:0]    mask;
    logic [31:0]    next_mask;
    logic           logic_fail_seen;
    logic           next_logic_fail_seen;
    logic [31:0]    latched;
    logic [31:0]    next_latched;
    dflp_sc_state_t sc_state;
    dflp_sc_state_t next_sc_state;
    logic [CNT_W-1:0] sc_cnt;
    logic [CNT_W-1:0] next_sc_cnt;
    logic           enable;
    logic           next_enable;
    logic           abort;
    logic           next_abort;
    logic [31:0]    src_vec;
    logic [31:0]    eff_mask;
    logic           recover_block;

    // ************************************************************
    // Source vector in mask bit order
    // ************************************************************
    always_comb begin
        src_vec                 = 32'h0000_0000;
        src_vec[BIT_FLASH_CRC]  = fault_src_in.flash_crc_bad;
        src_vec[BIT_INT_ERR]    = fault_src_in.selftest_fail;
        src_vec[BIT_SHORT]      = fault_src_in.short_det;
        src_vec[BIT_DRV_OT]     = fault_src_in.drive_ot;
        src_vec[BIT_MOT_OT]     = fault_src_in.motor_ot;
        src_vec[BIT_OVER_V]     = fault_src_in.over_v;
        src_vec[BIT_UNDER_V]    = fault_src_in.under_v;
        src_vec[BIT_FEEDBACK]   = fault_src_in.feedback;
        src_vec[BIT_PHASING]    = fault_src_in.phasing;
        src_vec[BIT_FOLLOW]     = fault_src_in.follow_err;
        src_vec[BIT_I2T_LIMIT]  = fault_src_in.i2t_limit;
    end

    // Fatal bits always act as masked; logic failure is report-only
    assign eff_mask = (mask & MASK_WR_BITS) | MASK_RO_ONES;

    // ************************************************************
    // Mask register
    // ************************************************************
    always_comb begin
        next_mask = mask;
        if (mask_wr_in) begin
            // Read-only bits keep their value whatever is written
            next_mask = mask_wdata_in & MASK_WR_BITS;
        end
        next_logic_fail_seen = logic_fail_seen | fault_src_in.logic_fail;
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mask            <= MASK_RESET;
            logic_fail_seen <= 1'b0;
        end else begin
            mask            <= next_mask;
            logic_fail_seen <= next_logic_fail_seen;
        end
    end

    always_comb begin
        mask_rdata_out                 = eff_mask;
        mask_rdata_out[BIT_LOGIC_FAIL] = logic_fail_seen;
    end

    // ************************************************************
    // Latched faults
    // ************************************************************
    always_comb begin
        next_latched = latched;
        if (fault_clr_in) begin
            next_latched = latched & ~(fault_clr_data_in & ~LATCH_FATAL);
        end
        // Set wins over a clear in the same cycle
        next_latched = next_latched | (src_vec & eff_mask);
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            latched <= LATCH_RESET;
        end else begin
            latched <= next_latched;
        end
    end

    assign latched_faults_out = latched;

    always_comb begin
        event_status_out                = 32'h0000_0000;
        event_status_out[EVT_FAULT_BIT] = |latched;
    end

    // ************************************************************
    // Short-circuit auto recovery
    // ************************************************************
    always_comb begin
        next_sc_state = sc_state;
        next_sc_cnt   = sc_cnt;
        case (sc_state)
            DFLP_SC_RUN: begin
                if (fault_src_in.short_det && !eff_mask[BIT_SHORT]) begin
                    next_sc_state = DFLP_SC_HOLD;
                    next_sc_cnt   = CNT_LOAD;
                end
            end
            DFLP_SC_HOLD: begin
                // A fresh short restarts the full off time
                if (fault_src_in.short_det) begin
                    next_sc_cnt = CNT_LOAD;
                end else if (sc_cnt == '0) begin
                    next_sc_state = DFLP_SC_RUN;
                end else begin
                    next_sc_cnt = sc_cnt - 1'b1;
                end
            end
            default: begin
                next_sc_state = DFLP_SC_RUN;
                next_sc_cnt   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sc_state <= DFLP_SC_RUN;
            sc_cnt   <= '0;
        end else begin
            sc_state <= next_sc_state;
            sc_cnt   <= next_sc_cnt;
        end
    end

    // ************************************************************
    // Enable and move abort
    // ************************************************************
    // Unmasked temperature, voltage, feedback and phasing faults hold the enable off only while active; a short also holds it for its off time
    assign recover_block = (fault_src_in.drive_ot && !eff_mask[BIT_DRV_OT])
                         | (fault_src_in.motor_ot && !eff_mask[BIT_MOT_OT])
                         | (fault_src_in.over_v   && !eff_mask[BIT_OVER_V])
                         | (fault_src_in.under_v  && !eff_mask[BIT_UNDER_V])
                         | (fault_src_in.feedback && !eff_mask[BIT_FEEDBACK])
                         | (fault_src_in.phasing  && !eff_mask[BIT_PHASING])
                         | (fault_src_in.short_det && !eff_mask[BIT_SHORT])
                         | (sc_state == DFLP_SC_HOLD);

    always_comb begin
        // Latched faults override any recovery of the cause
        next_enable = enable_req_in && (next_latched == 32'h0000_0000)
                    && !recover_block;
        next_abort  = fault_src_in.follow_err && !eff_mask[BIT_FOLLOW];
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            enable <= 1'b0;
            abort  <= 1'b0;
        end else begin
            enable <= next_enable;
            abort  <= next_abort;
        end
    end

    assign drive_enable_out = enable;
    assign abort_move_out   = abort;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_crc_bad;
        fault_src_in.flash_crc_bad;
    endsequence
    sequence s_disabled_faulted;
        !drive_enable_out && latched_faults_out[BIT_FLASH_CRC];
    endsequence

    property p_crc_fatal;
        s_crc_bad |=> s_disabled_faulted;
    endproperty
    a_crc_fatal: assert property (p_crc_fatal)
        else $error("Config corruption did not disable and latch");

    property p_selftest;
        fault_src_in.selftest_fail |=> !drive_enable_out && latched_faults_out[BIT_INT_ERR]
            && mask_rdata_out[BIT_INT_ERR];
    endproperty
    a_selftest: assert property (p_selftest)
        else $error("Selftest failure not latched");

    sequence s_short_soft;
        fault_src_in.short_det && !mask_rdata_out[BIT_SHORT];
    endsequence
    property p_short_hold;
        s_short_soft ##1 !fault_src_in.short_det [*8] |-> !drive_enable_out;
    endproperty
    a_short_hold: assert property (p_short_hold)
        else $error("Outputs re-enabled during short-circuit off time");

    property p_short_latch;
        fault_src_in.short_det && mask_rdata_out[BIT_SHORT] |=> latched_faults_out[BIT_SHORT];
    endproperty
    a_short_latch: assert property (p_short_latch)
        else $error("Masked short did not latch");

    property p_drv_ot_soft;
        fault_src_in.drive_ot && !mask_rdata_out[BIT_DRV_OT]
            && !latched_faults_out[BIT_DRV_OT]
            |=> !drive_enable_out && !latched_faults_out[BIT_DRV_OT];
    endproperty
    a_drv_ot_soft: assert property (p_drv_ot_soft)
        else $error("Drive overtemp recovery mode misbehaved");

    property p_uv_latch;
        fault_src_in.under_v && mask_rdata_out[BIT_UNDER_V]
            |=> latched_faults_out[BIT_UNDER_V] && event_status_out[EVT_FAULT_BIT];
    endproperty
    a_uv_latch: assert property (p_uv_latch)
        else $error("Under-voltage did not latch and flag");

    property p_follow_soft;
        fault_src_in.follow_err && !mask_rdata_out[BIT_FOLLOW]
            && !latched_faults_out[BIT_FOLLOW]
            |=> abort_move_out && !latched_faults_out[BIT_FOLLOW];
    endproperty
    a_follow_soft: assert property (p_follow_soft)
        else $error("Following error did not abort move");

    property p_i2t_latch;
        fault_src_in.i2t_limit && mask_rdata_out[BIT_I2T_LIMIT]
            |=> latched_faults_out[BIT_I2T_LIMIT];
    endproperty
    a_i2t_latch: assert property (p_i2t_latch)
        else $error("Current limiting did not latch");

    property p_logic_ro;
        mask_wr_in && !fault_src_in.logic_fail
            |=> $stable(mask_rdata_out[BIT_LOGIC_FAIL]);
    endproperty
    a_logic_ro: assert property (p_logic_ro)
        else $error("Write changed read-only logic failure bit");

    property p_event_flag;
        event_status_out[EVT_FAULT_BIT] == (latched_faults_out != 32'h0000_0000);
    endproperty
    a_event_flag: assert property (p_event_flag)
        else $error("Fault event flag disagrees with latched faults");

    property p_clear;
        fault_clr_in && fault_clr_data_in[BIT_PHASING] && !fault_src_in.phasing
            |=> !latched_faults_out[BIT_PHASING];
    endproperty
    a_clear: assert property (p_clear)
        else $error("Write-one clear failed");

    property p_latched_off;
        latched_faults_out != 32'h0000_0000 |-> !drive_enable_out;
    endproperty
    a_latched_off: assert property (p_latched_off)
        else $error("Drive enabled with a latched fault");

endmodule // dflp_fault_latch

// ### dflp_pkg.sv
package dflp_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned SHORT_OFF_MS  = 100;
    // Least time, so round up to whole cycles
    localparam int unsigned SHORT_OFF_CYC =
        (SHORT_OFF_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Fault mask / latched fault bit positions
    // ************************************************************
    localparam int unsigned BIT_FLASH_CRC  = 0;
    localparam int unsigned BIT_INT_ERR    = 1;
    localparam int unsigned BIT_SHORT      = 2;
    localparam int unsigned BIT_DRV_OT     = 3;
    localparam int unsigned BIT_MOT_OT     = 4;
    localparam int unsigned BIT_OVER_V     = 5;
    localparam int unsigned BIT_UNDER_V    = 6;
    localparam int unsigned BIT_FEEDBACK   = 7;
    localparam int unsigned BIT_PHASING    = 8;
    localparam int unsigned BIT_FOLLOW     = 9;
    localparam int unsigned BIT_I2T_LIMIT  = 10;
    localparam int unsigned BIT_LOGIC_FAIL = 11;
    localparam int unsigned EVT_FAULT_BIT  = 22;

    // Writable mask bits are 2..10; 0,1 read as one, 11 read-only
    localparam logic [31:0] MASK_WR_BITS   = 32'h0000_07FC;
    localparam logic [31:0] MASK_RO_ONES   = 32'h0000_0003;
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    localparam logic [31:0] LATCH_RESET    = 32'h0000_0000;
    // Fatal bits cannot be cleared by the host
    localparam logic [31:0] LATCH_FATAL    = 32'h0000_0003;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic logic_fail;
        logic i2t_limit;
        logic follow_err;
        logic phasing;
        logic feedback;
        logic under_v;
        logic over_v;
        logic motor_ot;
        logic drive_ot;
        logic short_det;
        logic selftest_fail;
        logic flash_crc_bad;
    } dflp_src_t;

    typedef enum logic {
        DFLP_SC_RUN  = 1'b0,
        DFLP_SC_HOLD = 1'b1
    } dflp_sc_state_t;

endpackage

// ### tb_dflp_fault_latch.sv
`timescale 1ns/1ps

module tb_dflp_fault_latch;
    import dflp_pkg::*;

    // ************************************************************
    // Bench signals
    // ************************************************************
    // Short off time cut down so the run stays short
    localparam int unsigned OFF_CYC = 20;

    logic        sys_clk_in;
    logic        reset_n_in;
    logic        mask_wr_in;
    logic [31:0] mask_wdata_in;
    logic [31:0] mask_rdata_out;
    logic        fault_clr_in;
    logic [31:0] fault_clr_data_in;
    logic [31:0] latched_faults_out;
    logic [31:0] event_status_out;
    dflp_src_t   fault_src_in;
    logic        enable_req_in;
    logic        drive_enable_out;
    logic        abort_move_out;
    int          miscompares;
    int          checked;
    int          b;

    dflp_fault_latch #(.SHORT_OFF_CYCLES(OFF_CYC)) uut (
        .sys_clk_in         (sys_clk_in),
        .reset_n_in         (reset_n_in),
        .mask_wr_in         (mask_wr_in),
        .mask_wdata_in      (mask_wdata_in),
        .mask_rdata_out     (mask_rdata_out),
        .fault_clr_in       (fault_clr_in),
        .fault_clr_data_in  (fault_clr_data_in),
        .latched_faults_out (latched_faults_out),
        .event_status_out   (event_status_out),
        .fault_src_in       (fault_src_in),
        .enable_req_in      (enable_req_in),
        .drive_enable_out   (drive_enable_out),
        .abort_move_out     (abort_move_out)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic step(input int cyc);
        repeat (cyc) @(negedge sys_clk_in);
    endtask

    function automatic logic [31:0] one(input int i);
        return 32'h0000_0001 << i;
    endfunction

    task automatic wr_mask(input logic [31:0] d);
        mask_wdata_in = d;
        mask_wr_in = 1'b1;
        step(1);
        mask_wr_in = 1'b0;
    endtask

    task automatic clr(input logic [31:0] d);
        fault_clr_data_in = d;
        fault_clr_in = 1'b1;
        step(1);
        fault_clr_in = 1'b0;
    endtask

    // Source held for cyc edges, then dropped
    task automatic pulse(input int i, input int cyc);
        fault_src_in = dflp_src_t'(12'h001 << i);
        step(cyc);
        fault_src_in = '0;
    endtask

    task automatic chk_en(input logic exp, input string what);
        chk(32'(drive_enable_out), 32'(exp), what);
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        miscompares = 0;
        checked = 0;
        reset_n_in = 1'b0;
        mask_wr_in = 1'b0;
        mask_wdata_in = 32'h0000_0000;
        fault_clr_in = 1'b0;
        fault_clr_data_in = 32'h0000_0000;
        fault_src_in = '0;
        enable_req_in = 1'b0;
        step(6);
        reset_n_in = 1'b1;
        chk(mask_rdata_out, 32'h0000_0003, "mask after reset");
        chk(latched_faults_out, LATCH_RESET, "latched after reset");
        chk(event_status_out, 32'h0000_0000, "event after reset");
        chk_en(1'b0, "enable after reset");
        enable_req_in = 1'b1;
        step(1);
        chk_en(1'b1, "enable on request");
        wr_mask(32'hFFFF_FFFF);
        chk(mask_rdata_out, 32'h0000_07FF, "mask all written");

        // Every programmable source latched, held, then cleared
        for (b = 2; b <= 10; b++) begin
            pulse(b, 1);
            chk(latched_faults_out, one(b), "latch set");
            chk(event_status_out, one(EVT_FAULT_BIT), "event fault");
            chk_en(1'b0, "latched disables");
            step(2);
            chk_en(1'b0, "stays off after recovery");
            clr(~one(b));
            chk(latched_faults_out, one(b), "zero bit keeps fault");
            // Let an edge pass so the strobe is not re-raised in one step
            step(1);
            clr(one(b));
            chk(latched_faults_out, 32'h0000_0000, "one bit clears");
            chk(event_status_out, 32'h0000_0000, "event drops");
            chk_en(1'b1, "enable back after clear");
        end

        // Clear while the cause is still active: set wins
        fault_src_in = dflp_src_t'(12'h100);
        clr(one(BIT_PHASING));
        chk(latched_faults_out, one(BIT_PHASING), "set wins over clear");
        fault_src_in = '0;
        step(1);
        clr(one(BIT_PHASING));
        chk(latched_faults_out, 32'h0000_0000, "clear after cause drops");
        chk_en(1'b1, "enable after late clear");

        // Recoverable sources follow the condition
        wr_mask(32'h0000_0000);
        chk(mask_rdata_out, 32'h0000_0003, "mask cleared");
        for (b = 3; b <= 8; b++) begin
            pulse(b, 2);
            chk_en(1'b0, "off while active");
            chk(latched_faults_out, 32'h0000_0000, "no latch");
            step(1);
            chk_en(1'b1, "back on after drop");
        end

        // Short with mask clear: timed off period
        pulse(2, 1);
        chk_en(1'b0, "short off");
        chk(latched_faults_out, 32'h0000_0000, "short no latch");
        step(OFF_CYC - 1);
        chk_en(1'b0, "short still off");
        for (b = 0; b < 4 && drive_enable_out !== 1'b1; b++) begin
            step(1);
        end
        chk_en(1'b1, "short re-enable");
        if (drive_enable_out !== 1'b1) begin
            tally_and_finish();
        end

        // Following error aborts only; current limit ignored
        pulse(9, 1);
        chk(32'(abort_move_out), 32'h0000_0001, "abort pulse");
        chk_en(1'b1, "stays enabled");
        step(1);
        chk(32'(abort_move_out), 32'h0000_0000, "abort ends");
        pulse(10, 2);
        chk_en(1'b1, "limit unmasked");
        chk(latched_faults_out, 32'h0000_0000, "limit no latch");

        // Logic failure is read-only status
        pulse(11, 1);
        chk(mask_rdata_out, 32'h0000_0803, "logic fail bit");
        wr_mask(32'h0000_0000);
        chk(mask_rdata_out, 32'h0000_0803, "logic fail kept");

        // Fatal faults cannot be cleared
        pulse(0, 1);
        chk(latched_faults_out, 32'h0000_0001, "config fault");
        chk(event_status_out, one(EVT_FAULT_BIT), "event fatal");
        chk_en(1'b0, "config disables");
        step(1);
        pulse(1, 1);
        chk(latched_faults_out, 32'h0000_0003, "selftest fault");
        clr(32'hFFFF_FFFF);
        step(2);
        chk(latched_faults_out, 32'h0000_0003, "fatal kept");
        chk_en(1'b0, "fatal stays off");

        // Second reset mid-run
        reset_n_in = 1'b0;
        step(2);
        reset_n_in = 1'b1;
        chk(latched_faults_out, LATCH_RESET, "latched re-reset");
        chk(mask_rdata_out, 32'h0000_0003, "mask re-reset");
        chk_en(1'b0, "enable held by reset");
        step(1);
        chk_en(1'b1, "enable after re-reset");
        tally_and_finish();
    end

endmodule // tb_dflp_fault_latch
